// ==== quirk_pkg.sv ====
// Package: constants for the PC/SP quirk decoder.
// Assumes a 20-bit address space and byte addressed program memory.
package quirk_pkg;
    localparam int          ADDR_W        = 20;
    localparam logic [19:0] PC_RESET      = 20'h00000;
    localparam logic [19:0] SP_RESET      = 20'h00000;
    localparam logic [19:0] LEN_SHORT_OP  = 20'h00002;
    localparam logic [19:0] LEN_LONG_OP   = 20'h00004;
    localparam logic [19:0] SP_PUSH_STEP  = 20'h00004;

    // Instruction classes presented by the decode stage
    typedef enum logic [3:0]
    {
        OP_OTHER,
        OP_ADDR_ARITH,     // address_add/subtract/compare, immediate
        OP_EXT_ARITH,      // 20-bit extended arithmetic forms
        OP_MOVE,
        OP_EXT_ADDR_PUSH,  // extended_address_push
        OP_PUSH,           // push / extended_push
        OP_ADDR_CALL,      // address_call, register operand
        OP_ADDR_CALL_IDX,  // address_call index(base)
        OP_COND_JUMP,
        OP_ROTATE_PC,
        OP_BIT_TEST
    } op_class_t;

    // Source addressing modes
    typedef enum logic [2:0]
    {
        AM_REGISTER,
        AM_IMMEDIATE,
        AM_ABSOLUTE,
        AM_SYMBOLIC,
        AM_INDEXED,
        AM_INDIRECT,
        AM_INDIRECT_INC
    } addr_mode_t;

    typedef enum logic [2:0]
    {
        CC_ZERO,
        CC_NOT_ZERO,
        CC_CARRY,
        CC_NO_CARRY,
        CC_NEGATIVE,
        CC_GREATER_EQUAL,
        CC_LESS,
        CC_ALWAYS
    } cond_t;
endpackage

// ==== reset_sync.sv ====
// Reset synchroniser: async assert, two-flop release.
// Assumes clk is free running.
module reset_sync
(
    // Clock and raw reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Synchronised reset
    output logic      rst_sync_n
);
    logic stage_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_ff   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            stage_ff   <= 1'b1;
            rst_sync_n <= stage_ff;
        end
    end
endmodule

// ==== pc_sp_quirk.sv ====
// PC/SP quirk decoder: forms PC, SP and stack results for one
// decoded instruction per strobe. Assumes decode supplies class,
// mode, operands and flags on the same clock.
//
// What this block does (RULE10 is a rule for software)
// RULE1: Immediate address add/sub/compare to PC counts two bytes, not four.
// RULE2: Plain move to PC uses the full instruction length, no offset error.
// RULE3: Extended 20-bit arithmetic forms to PC compute correctly.
// RULE4: Extended address push of @SP+ loads SP with the old top word.
// RULE5: Address call on PC pushes a return value two below correct.
// RULE6: Indexed call on SP after memory-mode push treats index as positive.
// RULE7: Register/immediate push or non-SP base keeps index sign extension.
// RULE8: Untaken listed conditional jump then rotate PC halts the CPU.
// RULE9: Bit test @Rx,PC omits its two opcode bytes from the PC value.
// RULE10: Software should insert a no-op between push and indexed SP call.
// RULE11: Otherwise PC-relative results use next instruction address.
module pc_sp_quirk
    import quirk_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Decoded instruction
    input  wire logic              instr_valid,
    input  wire op_class_t         op_class,
    input  wire addr_mode_t        src_mode,
    input  wire cond_t             jump_cond,
    input  wire logic              dst_is_pc,
    input  wire logic              src_is_sp,
    input  wire logic              base_is_sp,
    input  wire logic              is_subtract,
    input  wire logic              is_compare,
    input  wire logic [ADDR_W-1:0] imm_value,
    input  wire logic [15:0]       index_value,
    input  wire logic [ADDR_W-1:0] call_target,
    input  wire logic [ADDR_W-1:0] mem_word,
    input  wire logic [ADDR_W-1:0] bit_mask,
    input  wire logic              flag_z,
    input  wire logic              flag_c,
    input  wire logic              flag_n,
    input  wire logic              flag_v,
    // Results
    output logic [ADDR_W-1:0]      pc_ff,
    output logic [ADDR_W-1:0]      sp_ff,
    output logic [ADDR_W-1:0]      stack_data_ff,
    output logic                   stack_write_ff,
    output logic                   cpu_halted_ff,
    output logic                   bit_zero_ff,
    output logic [ADDR_W-1:0]      call_addr_ff
);
    ////////////////////////////////////////////////////////////////
    logic rst_sync_n;

    reset_sync u_reset_sync
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .rst_sync_n (rst_sync_n)
    );

    ////////////////////////////////////////////////////////////////
    // History of the previous instruction
    logic prev_mem_push_ff;
    logic prev_cond_jump_ff;
    logic prev_not_taken_ff;

    function automatic logic cond_holds(input cond_t c, input logic z,
        input logic cy, input logic n, input logic v);
        unique case (c)
            CC_ZERO:          cond_holds = z;
            CC_NOT_ZERO:      cond_holds = !z;
            CC_CARRY:         cond_holds = cy;
            CC_NO_CARRY:      cond_holds = !cy;
            CC_NEGATIVE:      cond_holds = n;
            CC_GREATER_EQUAL: cond_holds = !(n ^ v);
            CC_LESS:          cond_holds = n ^ v;
            CC_ALWAYS:        cond_holds = 1'b1;
        endcase
    endfunction

    wire logic active    = instr_valid && !cpu_halted_ff;
    wire logic is_taken  = cond_holds(jump_cond, flag_z, flag_c,
                                      flag_n, flag_v);
    wire logic listed_cc = (jump_cond != CC_ALWAYS);
    wire logic mem_mode  = (src_mode != AM_REGISTER) &&
                           (src_mode != AM_IMMEDIATE);

    ////////////////////////////////////////////////////////////////
    // PC value seen by the instruction
    wire logic [ADDR_W-1:0] full_len =
        (op_class == OP_ADDR_ARITH || op_class == OP_EXT_ARITH ||
         op_class == OP_ADDR_CALL_IDX) ? LEN_LONG_OP : LEN_SHORT_OP;
    wire logic [ADDR_W-1:0] next_pc = pc_ff + full_len;          // RULE11
    wire logic [ADDR_W-1:0] arith_pc =
        (op_class == OP_ADDR_ARITH) ? pc_ff + LEN_SHORT_OP       // RULE1
                                    : next_pc;                   // RULE2 RULE3
    wire logic [ADDR_W-1:0] arith_res =
        is_subtract ? arith_pc - imm_value : arith_pc + imm_value;

    // Bit test @Rx sees PC without its own opcode bytes; other modes see next_pc
    wire logic [ADDR_W-1:0] bit_pc =
        (src_mode == AM_INDIRECT) ? pc_ff : next_pc;             // RULE9 RULE11
    wire logic bit_zero = ((bit_pc & bit_mask) == '0);           // RULE9

    // Call return value
    wire logic [ADDR_W-1:0] call_ret =
        dst_is_pc ? next_pc - LEN_SHORT_OP : next_pc;            // RULE5
    wire logic [ADDR_W-1:0] call_tgt = dst_is_pc ? next_pc : call_target;

    // Index extension for indexed call
    wire logic drop_sign = base_is_sp && prev_mem_push_ff;       // RULE6 RULE7
    wire logic [ADDR_W-1:0] idx_ext = drop_sign
        ? {4'h0, index_value}
        : {{4{index_value[15]}}, index_value};
    wire logic [ADDR_W-1:0] idx_addr = call_target + idx_ext;

    // Rotate on PC right after an untaken listed jump
    wire logic halt_now = (op_class == OP_ROTATE_PC) &&
                          prev_cond_jump_ff && prev_not_taken_ff; // RULE8

    ////////////////////////////////////////////////////////////////
    // Next state
    logic [ADDR_W-1:0] nxt_pc;
    logic [ADDR_W-1:0] nxt_sp;
    logic [ADDR_W-1:0] nxt_stack;
    logic              nxt_write;
    logic [ADDR_W-1:0] nxt_call;

    always_comb
    begin
        nxt_pc    = next_pc;
        nxt_sp    = sp_ff;
        nxt_stack = stack_data_ff;
        nxt_write = 1'b0;
        nxt_call  = call_addr_ff;
        unique case (op_class)
            OP_ADDR_ARITH, OP_EXT_ARITH:
                if (dst_is_pc && !is_compare)
                    nxt_pc = arith_res;
            OP_MOVE:
                if (dst_is_pc)
                    nxt_pc = imm_value;
            OP_EXT_ADDR_PUSH:
            begin
                nxt_write = 1'b1;
                nxt_stack = mem_word;
                if (src_is_sp && src_mode == AM_INDIRECT_INC)
                    nxt_sp = mem_word;                           // RULE4
                else
                    nxt_sp = sp_ff - SP_PUSH_STEP;
            end
            OP_PUSH:
            begin
                nxt_write = 1'b1;
                nxt_stack = mem_word;
                nxt_sp    = sp_ff - LEN_SHORT_OP;
            end
            OP_ADDR_CALL:
            begin
                nxt_write = 1'b1;
                nxt_stack = call_ret;
                nxt_sp    = sp_ff - SP_PUSH_STEP;
                nxt_pc    = call_tgt;
                nxt_call  = call_tgt;
            end
            OP_ADDR_CALL_IDX:
            begin
                nxt_write = 1'b1;
                nxt_stack = next_pc;
                nxt_sp    = sp_ff - SP_PUSH_STEP;
                nxt_pc    = mem_word;
                nxt_call  = idx_addr;
            end
            OP_COND_JUMP:
                if (is_taken)
                    nxt_pc = next_pc + imm_value;
            OP_ROTATE_PC:
                if (halt_now)
                    nxt_pc = pc_ff;                              // RULE8
            OP_BIT_TEST, OP_OTHER:
                nxt_pc = next_pc;
            // Unused class codes just step over the word
            default:
                nxt_pc = next_pc;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Registers; a halted CPU only leaves by reset
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pc_ff             <= PC_RESET;
            sp_ff             <= SP_RESET;
            stack_data_ff     <= '0;
            stack_write_ff    <= 1'b0;
            call_addr_ff      <= '0;
            bit_zero_ff       <= 1'b0;
            cpu_halted_ff     <= 1'b0;
            prev_mem_push_ff  <= 1'b0;
            prev_cond_jump_ff <= 1'b0;
            prev_not_taken_ff <= 1'b0;
        end
        else if (active)
        begin
            pc_ff             <= nxt_pc;
            sp_ff             <= nxt_sp;
            stack_data_ff     <= nxt_stack;
            stack_write_ff    <= nxt_write;
            call_addr_ff      <= nxt_call;
            cpu_halted_ff     <= halt_now;                       // RULE8
            if (op_class == OP_BIT_TEST && dst_is_pc)
                bit_zero_ff   <= bit_zero;                       // RULE9
            prev_mem_push_ff  <= (op_class == OP_PUSH) && mem_mode;
            prev_cond_jump_ff <= (op_class == OP_COND_JUMP) && listed_cc;
            prev_not_taken_ff <= !is_taken;
        end
        else
        begin
            stack_write_ff    <= 1'b0;
        end
    end
endmodule

// ==== pc_sp_quirk_monitor.sv ====
// Checker: timing relations at the quirk decoder ports.
// Assumes it is bound to pc_sp_quirk; one clock domain.
module pc_sp_quirk_monitor
    import quirk_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Decoded instruction
    input wire logic        instr_valid,
    input wire op_class_t   op_class,
    input wire addr_mode_t  src_mode,
    input wire logic        dst_is_pc,
    input wire logic        src_is_sp,
    input wire logic        is_subtract,
    input wire logic        is_compare,
    input wire logic [19:0] imm_value,
    input wire logic [19:0] mem_word,
    input wire logic [19:0] bit_mask,
    // Results
    input wire logic [19:0] pc_ff,
    input wire logic [19:0] sp_ff,
    input wire logic [19:0] stack_data_ff,
    input wire logic        stack_write_ff,
    input wire logic        cpu_halted_ff,
    input wire logic        bit_zero_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire take = instr_valid && !cpu_halted_ff;
    wire pcw  = take && dst_is_pc;
    wire add  = !is_subtract && !is_compare;
    wire stk  = op_class == OP_PUSH || op_class == OP_EXT_ADDR_PUSH
        || op_class == OP_ADDR_CALL || op_class == OP_ADDR_CALL_IDX;
    ////////////////////////////////////////////////////////////////////////
    halt_hold_a: assert property (cpu_halted_ff |=> cpu_halted_ff
        && $stable(pc_ff)) else $error("halt dropped or pc moved");
    arith_add_a: assert property (pcw && op_class == OP_ADDR_ARITH
        && add |=> pc_ff == $past(pc_ff) + 20'h2 + $past(imm_value))
        else $error("address add to pc wrong");
    arith_sub_a: assert property (pcw && op_class == OP_ADDR_ARITH
        && is_subtract && !is_compare
        |=> pc_ff == $past(pc_ff) + 20'h2 - $past(imm_value))
        else $error("address subtract to pc wrong");
    compare_pc_a: assert property (pcw && op_class == OP_ADDR_ARITH
        && is_compare |=> pc_ff == $past(pc_ff) + 20'h4)
        else $error("address compare moved pc");
    ext_arith_a: assert property (pcw && op_class == OP_EXT_ARITH
        && add |=> pc_ff == $past(pc_ff) + 20'h4 + $past(imm_value))
        else $error("extended add to pc wrong");
    move_pc_a: assert property (pcw && op_class == OP_MOVE
        |=> pc_ff == $past(imm_value)) else $error("move to pc wrong");
    sp_load_a: assert property (take && op_class == OP_EXT_ADDR_PUSH
        && src_is_sp && src_mode == AM_INDIRECT_INC
        |=> sp_ff == $past(mem_word)) else $error("sp not loaded");
    call_ret_a: assert property (pcw && op_class == OP_ADDR_CALL
        |=> stack_data_ff == $past(pc_ff) && sp_ff == $past(sp_ff) - 20'h4)
        else $error("call return value wrong");
    bit_pc_a: assert property (pcw && op_class == OP_BIT_TEST
        && src_mode == AM_INDIRECT |=> bit_zero_ff ==
        (($past(pc_ff) & $past(bit_mask)) == 20'h0))
        else $error("bit test flag wrong");
    stack_write_a: assert property (take && stk
        |=> stack_write_ff) else $error("stack write missing");
    write_pulse_a: assert property (!(take && stk)
        |=> !stack_write_ff) else $error("stack write not a pulse");
endmodule

// ==== quirk_mem_model.sv ====
// Partner: stack memory on the data bus.
// Assumes word slot from sp bits 4:1; bench picks the read slot.
module quirk_mem_model
(
    // Clock
    input  wire logic        clk,
    // Bus
    input  wire logic [3:0]  rd_idx,
    input  wire logic        stack_write_ff,
    input  wire logic [19:0] sp_ff,
    input  wire logic [19:0] stack_data_ff,
    output logic [19:0]      mem_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [19:0] mem [16];
    // Small window only; slots alias every 32 bytes
    initial for (int i = 0; i < 16; i++) mem[i] = 20'h0a000 + 20'(i);
    always @(posedge clk) if (stack_write_ff) mem[sp_ff[4:1]] <= stack_data_ff;
    assign mem_word = mem[rd_idx];
endmodule

// ==== pc_sp_quirk_tb.sv ====
// Bench: drives decoded instructions, scores results from a queue.
// Assumes pc_sp_quirk, the monitor and the memory model compiled first.
module pc_sp_quirk_tb
    import quirk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct { int sel; logic [19:0] exp; } note_t;
    logic clk = 0, rst_n = 0, instr_valid = 0, dst_is_pc = 0, src_is_sp = 0;
    logic base_is_sp = 0, is_subtract = 0, is_compare = 0, flag_c = 0;
    logic flag_z = 0, flag_n = 0, flag_v = 0;
    op_class_t op_class = OP_OTHER;
    addr_mode_t src_mode = AM_REGISTER;
    cond_t jump_cond = CC_ALWAYS;
    logic [19:0] imm_value = 0, call_target = 0, bit_mask = 0, pc, ret;
    logic [15:0] index_value = 0;
    logic [3:0] rd_idx = 0;
    wire [19:0] mem_word, pc_ff, sp_ff, stack_data_ff, call_addr_ff;
    wire stack_write_ff, cpu_halted_ff, bit_zero_ff;
    note_t q[$];
    int mismatches = 0, comparisons = 0;
    always #50 clk = ~clk;
    pc_sp_quirk DUT (.clk, .rst_n, .instr_valid, .op_class, .src_mode,
        .jump_cond, .dst_is_pc, .src_is_sp, .base_is_sp, .is_subtract,
        .is_compare, .imm_value, .index_value, .call_target, .mem_word,
        .bit_mask, .flag_z, .flag_c, .flag_n, .flag_v, .pc_ff, .sp_ff,
        .stack_data_ff, .stack_write_ff, .cpu_halted_ff, .bit_zero_ff,
        .call_addr_ff);
    quirk_mem_model mem (.clk, .rd_idx, .stack_write_ff, .sp_ff,
        .stack_data_ff, .mem_word);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Valid stays high so back-to-back issue never toggles it twice
    task automatic go(input op_class_t op, input int sel,
                      input logic [19:0] exp);
        op_class = op;
        instr_valid = 1;
        if (sel < 6) q.push_back('{sel, exp});
        @(posedge clk);
        #10;
    endtask
    always @(posedge clk)
    begin
        note_t n;
        if (instr_valid && cpu_halted_ff !== 1'b1 && q.size() > 0)
        begin
            n = q.pop_front();
            #20;
            case (n.sel)
                0: check(pc_ff, n.exp);
                1: check(sp_ff, n.exp);
                2: check(stack_data_ff, n.exp);
                3: check({19'h0, cpu_halted_ff}, n.exp);
                4: check({19'h0, bit_zero_ff}, n.exp);
                default: check(call_addr_ff, n.exp);
            endcase
        end
    end
    initial
    begin
        #3000000;
        mismatches++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h6a94c8ce));
        repeat (8) @(posedge clk);
        #10 rst_n = 1;
        repeat (3) @(posedge clk);
        #10 dst_is_pc = 1;
        imm_value = 20'($urandom) & 20'h0fffe;
        pc = imm_value;
        go(OP_MOVE, 0, pc);
        for (int k = 0; k < 2; k++)
        begin
            is_subtract = k[0];
            imm_value = 20'($urandom) & 20'h00ffe;
            pc = k ? pc + 20'h2 - imm_value : pc + 20'h2 + imm_value;
            go(OP_ADDR_ARITH, 0, pc);
        end
        is_subtract = 0;
        pc = pc + 20'h4 + imm_value;
        go(OP_EXT_ARITH, 0, pc);
        is_compare = 1;
        pc = pc + 20'h4;
        go(OP_ADDR_ARITH, 0, pc);
        is_compare = 0;
        ret = pc;
        go(OP_ADDR_CALL, 2, ret);
        $display("pc arithmetic and call done");
        imm_value = 20'h01000;
        go(OP_MOVE, 6, 0);
        src_mode = AM_INDIRECT;
        bit_mask = 20'h00002;
        go(OP_BIT_TEST, 4, 20'h1);
        dst_is_pc = 0;
        src_is_sp = 1;
        src_mode = AM_INDIRECT_INC;
        rd_idx = 4'he;
        go(OP_EXT_ADDR_PUSH, 1, ret);
        $display("bit test and stack load done");
        src_is_sp = 0;
        call_target = 20'h20000;
        index_value = 16'hfff0;
        for (int k = 0; k < 4; k++)
        begin
            src_mode = k == 1 ? AM_REGISTER : AM_INDEXED;
            base_is_sp = k != 2;
            go(OP_PUSH, 6, 0);
            if (k == 3) go(OP_OTHER, 6, 0);
            go(OP_ADDR_CALL_IDX, 5, k ? 20'h1fff0 : 20'h2fff0);
        end
        $display("indexed call done");
        dst_is_pc = 1;
        imm_value = 20'h03000;
        go(OP_MOVE, 6, 0);
        jump_cond = CC_CARRY;
        flag_c = 1;
        go(OP_COND_JUMP, 0, 20'h06002);
        go(OP_ROTATE_PC, 3, 20'h0);
        flag_c = 0;
        go(OP_COND_JUMP, 0, 20'h06006);
        go(OP_ROTATE_PC, 3, 20'h1);
        op_class = OP_MOVE;
        repeat (3) @(posedge clk);
        #10 check(pc_ff, 20'h06006);
        instr_valid = 0;
        rst_n = 0;
        repeat (3) @(posedge clk);
        #10 check({19'h0, cpu_halted_ff}, 20'h0);
        check(pc_ff, PC_RESET);
        $display("halt and reset done");
        report_and_stop();
    end
endmodule
bind pc_sp_quirk pc_sp_quirk_monitor mon (.clk, .rst_n, .instr_valid,
    .op_class, .src_mode, .dst_is_pc, .src_is_sp, .is_subtract, .is_compare,
    .imm_value, .mem_word, .bit_mask, .pc_ff, .sp_ff, .stack_data_ff,
    .stack_write_ff, .cpu_halted_ff, .bit_zero_ff);
